// [rtl/hfd_fifo_bank.sv]
/*
 * HDLC FIFO bank with host access: 16 FIFOs, each with a transmit and a
 * receive queue, reached over AHB-Lite; line side pops transmit bytes and
 * pushes receive bytes on one shared strobe that carries a FIFO number.
 * Assumes a single 100 MHz clock and synchronous line inputs.
 */
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps

module hfd_fifo_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt
    output logic irq,
    // Line side
    input wire logic line_strobe,
    input wire logic [3:0] line_fifo,
    input wire logic [7:0] line_rx_byte,
    output logic [7:0] line_tx_byte,
    output logic line_tx_valid
);
    import hfd_pkg::*;

    // ==========================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Two-stage release; assertion stays asynchronous
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Declarations
    hfd_state_e st_q;
    logic [7:0] idx_q;
    logic write_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic [SEL_W-1:0] sel_q;
    logic transp_q;
    logic [THR_W-1:0] thr_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_evt;
    logic irq_q;
    logic [PTR_W-1:0] wr_q [NUM_Q];
    logic [PTR_W-1:0] rd_q [NUM_Q];
    logic [NUM_FIFO-1:0] hold_q;
    logic [NUM_Q-1:0] fill_q;
    logic [7:0] mem_q [256];
    logic [7:0] line_tx_byte_q;
    logic line_tx_valid_q;
    logic take, acc_wr, acc_rd, is_inc, is_data, sel_tx;
    logic [3:0] cnt_sel, cnt_ltx, cnt_lrx;
    logic host_push, host_pop, host_ovf, host_udf;
    logic [4:0] ltx, lrx;
    logic line_pop, line_repeat, line_udf, line_push, line_ovf;

    // Bytes held in one queue; 4-bit pointers over 8 slots keep full apart from empty
    function automatic logic [3:0] q_count(input logic [PTR_W-1:0] w, input logic [PTR_W-1:0] r);
        return w - r;
    endfunction

    // ==========================================================
    // Bus slave: one address phase, one wait state, then answer
    assign take = hsel && htrans[1] && hready && (st_q == ST_IDLE);
    assign acc_wr = (st_q == ST_ACCESS) && write_q;
    assign acc_rd = (st_q == ST_ACCESS) && !write_q;

    // Wait state lets a write land before any later read samples state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            idx_q <= 8'h00;
            write_q <= 1'b0;
            hreadyout_q <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (take) begin
                        st_q <= ST_ACCESS;
                        idx_q <= haddr[IDX_MSB:IDX_LSB];
                        write_q <= hwrite;
                        hreadyout_q <= 1'b0;
                    end
                end
                ST_ACCESS: begin
                    st_q <= ST_IDLE;
                    hreadyout_q <= 1'b1;
                end
                default: begin
                    st_q <= ST_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Host data path decode
    // selection steers access
    assign sel_tx = !sel_q[SEL_DIR_BIT];
    assign is_inc = (idx_q == IDX_DATA_INC);
    assign is_data = is_inc || (idx_q == IDX_DATA_HOLD);
    assign cnt_sel = q_count(wr_q[sel_q], rd_q[sel_q]);
    assign host_push = acc_wr && is_data && sel_tx && (cnt_sel != Q_FULL_CNT);
    assign host_ovf = acc_wr && is_data && sel_tx && (cnt_sel == Q_FULL_CNT);
    assign host_pop = acc_rd && is_data && !sel_tx && (cnt_sel != Q_EMPTY_CNT);
    assign host_udf = acc_rd && is_data && !sel_tx && (cnt_sel == Q_EMPTY_CNT);

    // Line side: transmit queue drains, receive queue fills
    assign ltx = {line_fifo, 1'b0};
    assign lrx = {line_fifo, 1'b1};
    assign cnt_ltx = q_count(wr_q[ltx], rd_q[ltx]);
    assign cnt_lrx = q_count(wr_q[lrx], rd_q[lrx]);
    assign line_pop = line_strobe && (cnt_ltx != Q_EMPTY_CNT);
    assign line_repeat = line_strobe && (cnt_ltx == Q_EMPTY_CNT) && hold_q[line_fifo]
        && transp_q;
    assign line_udf = line_strobe && (cnt_ltx == Q_EMPTY_CNT) && !line_repeat;
    assign line_push = line_strobe && (cnt_lrx != Q_FULL_CNT);
    assign line_ovf = line_strobe && (cnt_lrx == Q_FULL_CNT);

    // ==========================================================
    // Queue storage; no reset, as data content is undefined at start
    always_ff @(posedge clk) begin
        if (host_push) begin
            mem_q[{sel_q, wr_q[sel_q][SLOT_W-1:0]}] <= hwdata[7:0];
        end
        if (line_push) begin
            mem_q[{lrx, wr_q[lrx][SLOT_W-1:0]}] <= line_rx_byte;
        end
    end

    // Pointers: host and line touch opposite directions, so never the same entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_Q; i++) begin
                wr_q[i] <= 4'h0;
                rd_q[i] <= 4'h0;
            end
        end else begin
            if (host_push && is_inc) begin
                wr_q[sel_q] <= wr_q[sel_q] + 4'h1;
            end
            if (host_pop && is_inc) begin
                rd_q[sel_q] <= rd_q[sel_q] + 4'h1;
            end
            if (line_push) begin
                wr_q[lrx] <= wr_q[lrx] + 4'h1;
            end
            if (line_pop) begin
                rd_q[ltx] <= rd_q[ltx] + 4'h1;
            end
        end
    end

    // holding write in transparent mode marks byte for repeat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 16'h0000;
        end else if (host_push) begin
            hold_q[sel_q[SEL_W-1:1]] <= !is_inc && transp_q;
        end
    end

    // Line transmit output; empty slot at rd equals held slot at wr
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_tx_byte_q <= 8'h00;
            line_tx_valid_q <= 1'b0;
        end else begin
            line_tx_valid_q <= line_pop || line_repeat;
            if (line_pop || line_repeat) begin
                line_tx_byte_q <= mem_q[{ltx, rd_q[ltx][SLOT_W-1:0]}];
            end
        end
    end

    // ==========================================================
    // Fill flags, one per queue; flag index equals queue index
    for (genvar g = 0; g < NUM_Q; g++) begin : g_fill
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                fill_q[g] <= 1'b0;
            end else begin
                fill_q[g] <= (q_count(wr_q[g], rd_q[g]) >= thr_q);
            end
        end
    end

    // ==========================================================
    // Software registers; fill and count have no write path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= SEL_RST;
            transp_q <= 1'b0;
            thr_q <= THR_RST;
            irq_mask_q <= IRQ_RST;
        end else if (acc_wr) begin
            case (idx_q)
                IDX_SEL: sel_q <= hwdata[SEL_W-1:0];
                IDX_CTRL: transp_q <= hwdata[CTRL_TRANSP_BIT];
                IDX_THR: thr_q <= hwdata[THR_W-1:0];
                IDX_IRQ_MASK: irq_mask_q <= hwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data mux; unmapped indices read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx_q)
            IDX_COUNT: rd_mux = {28'h000_0000, cnt_sel};
            IDX_FILL0, IDX_FILL1, IDX_FILL2, IDX_FILL3:
                rd_mux = {24'h00_0000, fill_q[{idx_q[1:0], 3'h0} +: 8]};
            IDX_DATA_INC, IDX_DATA_HOLD:
                rd_mux = host_pop ? {24'h00_0000, mem_q[{sel_q, rd_q[sel_q][SLOT_W-1:0]}]}
                    : 32'h0000_0000;
            IDX_SEL: rd_mux = {27'h000_0000, sel_q};
            IDX_CTRL: rd_mux = {31'h0000_0000, transp_q};
            IDX_THR: rd_mux = {28'h000_0000, thr_q};
            IDX_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_q};
            IDX_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data held until the next read answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (acc_rd) begin
            hrdata_q <= rd_mux;
        end
    end

    // ==========================================================
    // Interrupts: sticky, read clears, a new event beats the clear
    assign irq_evt = {line_ovf, line_udf, host_udf, host_ovf};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            if (acc_rd && idx_q == IDX_IRQ_STAT) begin
                irq_stat_q <= irq_evt;
                irq_q <= |(irq_evt & irq_mask_q);
            end else begin
                irq_stat_q <= irq_stat_q | irq_evt;
                irq_q <= |((irq_stat_q | irq_evt) & irq_mask_q);
            end
        end
    end

    // Outputs straight from flops; response is always OKAY
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign irq = irq_q;
    assign line_tx_byte = line_tx_byte_q;
    assign line_tx_valid = line_tx_valid_q;

    // ==========================================================
    // Assertions
    property p_count_read;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && idx_q == IDX_COUNT) |=> (hrdata_q == {28'h000_0000, $past(cnt_sel)});
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong");

    property p_count_zero;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && idx_q == IDX_COUNT && wr_q[sel_q] == rd_q[sel_q])
            |=> (hrdata_q[7:0] == COUNT_RST);
    endproperty
    a_count_zero: assert property (p_count_zero) else $error("empty count not zero");

    property p_fill_bit0;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && idx_q == IDX_FILL0) |=> (hrdata_q[1:0] == $past(fill_q[1:0]));
    endproperty
    a_fill_bit0: assert property (p_fill_bit0) else $error("fill bit order wrong");

    property p_fill_last;
        @(posedge clk) disable iff (!rst_n)
        (acc_rd && idx_q == IDX_FILL3) |=> (hrdata_q[7:0] == $past(fill_q[31:24]));
    endproperty
    a_fill_last: assert property (p_fill_last) else $error("fill register map wrong");

    property p_fill_reset;
        @(posedge clk) disable iff (!reset_n)
        (rst_n && !$past(rst_n)) |-> (fill_q == 32'h0000_0000);
    endproperty
    a_fill_reset: assert property (p_fill_reset) else $error("fill not clear at reset");

    property p_inc_push;
        @(posedge clk) disable iff (!rst_n)
        (host_push && is_inc) |=> (wr_q[$past(sel_q)] == $past(wr_q[sel_q]) + 4'h1);
    endproperty
    a_inc_push: assert property (p_inc_push) else $error("pointer not advanced");

    property p_hold_push;
        @(posedge clk) disable iff (!rst_n)
        (host_push && !is_inc) |=> (wr_q[$past(sel_q)] == $past(wr_q[sel_q]));
    endproperty
    a_hold_push: assert property (p_hold_push) else $error("holding write moved pointer");

    property p_repeat;
        @(posedge clk) disable iff (!rst_n)
        line_repeat |=> (line_tx_valid_q
            && line_tx_byte_q == $past(mem_q[{ltx, wr_q[ltx][SLOT_W-1:0]}]));
    endproperty
    a_repeat: assert property (p_repeat) else $error("held byte not repeated");

    property p_fill_thr;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> (fill_q[0] == ($past(q_count(wr_q[0], rd_q[0])) >= $past(thr_q)));
    endproperty
    a_fill_thr: assert property (p_fill_thr) else $error("fill flag off threshold");

endmodule

// [rtl/hfd_pkg.sv]
/*
 * Shared constants for the HDLC FIFO bank host access block: register
 * indices, field positions, reset values, queue geometry and FSM states.
 * Assumes a 32-bit AHB-Lite bus; the byte address is four times the index.
 */
package hfd_pkg;

    // ==========================================================
    // Queue geometry
    localparam int unsigned NUM_FIFO = 16;
    localparam int unsigned NUM_Q = 32;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned SLOT_W = 3;
    localparam logic [3:0] Q_FULL_CNT = 4'h8;
    localparam logic [3:0] Q_EMPTY_CNT = 4'h0;

    // ==========================================================
    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_COUNT = 8'h14;
    localparam logic [7:0] IDX_FILL0 = 8'h24;
    localparam logic [7:0] IDX_FILL1 = 8'h25;
    localparam logic [7:0] IDX_FILL2 = 8'h26;
    localparam logic [7:0] IDX_FILL3 = 8'h27;
    localparam logic [7:0] IDX_DATA_INC = 8'h80;
    localparam logic [7:0] IDX_DATA_HOLD = 8'h84;
    localparam logic [7:0] IDX_SEL = 8'h10;
    localparam logic [7:0] IDX_CTRL = 8'h11;
    localparam logic [7:0] IDX_THR = 8'h12;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h13;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h15;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;

    // ==========================================================
    // Fields and reset values
    localparam int unsigned SEL_W = 5;
    localparam int unsigned SEL_DIR_BIT = 0;
    localparam int unsigned CTRL_TRANSP_BIT = 0;
    localparam int unsigned THR_W = 4;
    localparam logic [3:0] THR_RST = 4'h4;
    localparam logic [4:0] SEL_RST = 5'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_HOST_OVF = 0;
    localparam int unsigned IRQ_HOST_UDF = 1;
    localparam int unsigned IRQ_LINE_UDF = 2;
    localparam int unsigned IRQ_LINE_OVF = 3;
    localparam logic [3:0] IRQ_RST = 4'h0;

    // ==========================================================
    // Bus slave states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } hfd_state_e;

endpackage

// [sim/hfd_host_model.sv]
/*
 * Host processor model: an AHB-Lite master doing single word transfers.
 * Assumes the one slave's hreadyout is fed back to it as hready.
 */
`timescale 1ns/100ps
module hfd_host_model (
    // Clock
    input wire logic clk,
    // Master outputs
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Slave answer
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    import hfd_pkg::*;
    logic rdy_s;
    logic [31:0] rd_s;
    // ==========================================================
    // Bus idle at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Slave moves only on rising edges; the falling edge copy avoids a race
    always @(negedge clk) begin
        rdy_s <= hready;
        rd_s <= hrdata;
    end
    // One transfer: address held until ready, then data phase until ready
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge clk);
        while (rdy_s !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (rdy_s !== 1'b1) @(posedge clk);
        rd = rd_s;
    endtask
    task automatic select(input logic [3:0] fifo, input logic rx);
        logic [31:0] unused;
        xfer(1'b1, IDX_SEL, {27'h0, fifo, rx}, unused);
    endtask
    task automatic write_last(input logic [7:0] b);
        logic [31:0] unused;
        xfer(1'b1, IDX_DATA_HOLD, {24'h0, b}, unused);
    endtask
endmodule

// [sim/tb_hdlc_fifo_data_and_fill_status.sv]
/*
 * Self-checking bench for the FIFO bank host access block.
 * Assumes the host model on the bus and line side strobes from the bench.
 */
`timescale 1ns/100ps
module tb_hdlc_fifo_data_and_fill_status;
    import hfd_pkg::*;
    logic clk, reset_n, hsel, hwrite, hready, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic line_strobe, line_tx_valid;
    logic [3:0] line_fifo;
    logic [7:0] line_rx_byte, line_tx_byte;
    int n_errors = 0;
    int n_compared = 0;
    hfd_fifo_bank i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .line_strobe(line_strobe), .line_fifo(line_fifo), .line_rx_byte(line_rx_byte),
        .line_tx_byte(line_tx_byte), .line_tx_valid(line_tx_valid));
    hfd_host_model i_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    // ==========================================================
    // Helpers
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        i_host.xfer(1'b1, idx, {24'h0, v}, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        i_host.xfer(1'b0, idx, 32'h0, d);
        chk(d, {24'h0, exp});
    endtask
    // One line service cycle; the answer stands for the cycle after the taking edge
    task automatic strobe(input logic [3:0] f, input logic [7:0] b, input logic [8:0] exp);
        @(posedge clk);
        line_strobe <= 1'b1;
        line_fifo <= f;
        line_rx_byte <= b;
        @(posedge clk);
        line_strobe <= 1'b0;
        #1;
        if (exp[8]) chk({23'h0, line_tx_valid, line_tx_byte}, {23'h0, exp});
        else chk({31'h0, line_tx_valid}, 32'h0);
    endtask
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(IDX_COUNT, COUNT_RST);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_FILL0 + 8'(i), 8'hFF);
            rd(IDX_FILL0 + 8'(i), 8'h00);
        end
        rd(8'h3F, 8'h00);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_irq;
        wr(IDX_IRQ_MASK, 8'h02);
        i_host.select(4'h0, 1'b1);
        rd(IDX_DATA_INC, 8'h00);
        chk({31'h0, irq}, 32'h1);
        rd(IDX_IRQ_STAT, 8'h02);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_MASK, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_count;
        i_host.select(4'h3, 1'b0);
        for (int i = 1; i <= 3; i++) wr(IDX_DATA_INC, 8'(i));
        rd(IDX_COUNT, 8'h03);
        wr(IDX_DATA_HOLD, 8'h44);
        rd(IDX_COUNT, 8'h03);
        wr(IDX_DATA_INC, 8'h55);
        rd(IDX_COUNT, 8'h04);
        rd(IDX_FILL0, 8'h01 << 6);
        rd(IDX_FILL1, 8'h00);
        wr(IDX_THR, 8'h05);
        rd(IDX_FILL0, 8'h00);
        wr(IDX_THR, 8'h04);
        for (int i = 0; i < 4; i++) wr(IDX_DATA_INC, 8'h60 + 8'(i));
        wr(IDX_DATA_INC, 8'h77);
        rd(IDX_COUNT, 8'h08);
        rd(IDX_IRQ_STAT, 8'h01);
        $display("test count done");
    endtask
    task automatic t_rx;
        for (int i = 0; i < 9; i++) strobe(4'hD, 8'hA0 + 8'(i), 9'h000);
        i_host.select(4'hD, 1'b1);
        rd(IDX_COUNT, 8'h08);
        rd(IDX_FILL3, 8'h01 << 3);
        rd(IDX_DATA_HOLD, 8'hA0);
        rd(IDX_COUNT, 8'h08);
        for (int i = 0; i < 6; i++) rd(IDX_DATA_INC, 8'hA0 + 8'(i));
        rd(IDX_COUNT, 8'h02);
        rd(IDX_FILL3, 8'h00);
        rd(IDX_IRQ_STAT, 8'h0C);
        $display("test rx done");
    endtask
    task automatic t_transp;
        wr(IDX_CTRL, 8'h01);
        i_host.select(4'h5, 1'b0);
        i_host.write_last(8'hA5);
        rd(IDX_COUNT, 8'h00);
        strobe(4'h5, 8'h00, 9'h1A5);
        strobe(4'h5, 8'h00, 9'h1A5);
        wr(IDX_DATA_INC, 8'h3C);
        strobe(4'h5, 8'h00, 9'h13C);
        $display("test transparent done");
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        reset_n = 1'b0;
        line_strobe = 1'b0;
        line_fifo = 4'h0;
        line_rx_byte = 8'h00;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_irq();
        t_count();
        t_rx();
        t_transp();
        test_done();
    end
    // The whole sequence needs about 260 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule
